// ---- verilog/rcx_defs.svh ----
`ifndef RCX_DEFS_SVH
`define RCX_DEFS_SVH

// ==========================================================================
// Device register map, offsets within one channel page
// ==========================================================================
`define RCX_ADDR_W          12
`define RCX_INT_STAT_ADDR   12'h70b
`define RCX_INT_EN_ADDR     12'h70f
`define RCX_MEMCTL_ADDR     12'h713
`define RCX_DATA_B3_ADDR    12'h714
`define RCX_DATA_B0_ADDR    12'h717
`define RCX_CNT_B3_ADDR     12'h74c
`define RCX_CNT_STRIDE      12'h010
`define RCX_CNT_ADDR_MASK   12'hfcc

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define RCX_FLUSH_N_BIT     4
`define RCX_CLAV_BIT        3
`define RCX_EXTR_INT_BIT    5
`define RCX_EXTR_OVF_BIT    3
`define RCX_INT_EN_W        6
`define RCX_INT_EN_RESET    6'h00
`define RCX_MEMCTL_FLUSH    8'h00
`define RCX_MEMCTL_RUN      8'h10

// ==========================================================================
// Cell geometry
// ==========================================================================
`define RCX_WORDS_PER_CELL  14
`define RCX_LAST_WORD       4'hd
`define RCX_CELL_BYTES      56
`define RCX_FILTERS         4

// ==========================================================================
// Host controller command port offsets
// ==========================================================================
`define RCX_H_CMD_ADDR      6'h00
`define RCX_H_IRQ_STAT_ADDR 6'h01
`define RCX_H_IRQ_MASK_ADDR 6'h02
`define RCX_H_COUNT_ADDR    6'h03
`define RCX_H_CELL_BASE     6'h10
`define RCX_H_CMD_FLUSH     0
`define RCX_H_CMD_CELL      1
`define RCX_H_CMD_COUNT     2
`define RCX_H_CMD_REG       3
`define RCX_H_EV_CELL       0
`define RCX_H_EV_COUNT      1

`endif

// ---- verilog/rcx_pkg.sv ----
package rcx_pkg;

  typedef logic [7:0]  rcx_byte_t;
  typedef logic [31:0] rcx_word_t;
  typedef logic [11:0] rcx_addr_t;

  typedef enum logic [3:0] {
    RCX_ST_FLUSH_LO,
    RCX_ST_FLUSH_HI,
    RCX_ST_IDLE,
    RCX_ST_POLL_RD,
    RCX_ST_POLL_CHK,
    RCX_ST_DATA_RD,
    RCX_ST_DATA_CAP,
    RCX_ST_CNT_RD,
    RCX_ST_CNT_CAP
  } rcx_host_state_t;

endpackage

// ---- verilog/rcx_link_if.sv ----
`timescale 1ns/1ps

interface rcx_link_if;
  import rcx_pkg::*;

  rcx_addr_t addr;
  rcx_byte_t wdata;
  logic      wr;
  logic      rd;
  rcx_byte_t rdata;
  logic      int_n;

  modport device (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output int_n
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  int_n
  );
endinterface

// ---- verilog/rcx_device_end.sv ----
`timescale 1ns/1ps
`include "rcx_defs.svh"

// Notes on behaviour
// R01: Host reads counter bytes high to low.
// R02: Copied inbound cells are stored for host.
// R03: Cells read as 32-bit words, 56 bytes.
// R04: Host reads fourteen words per cell.
// R05: Active-low flush in control bit 4.
// R06: Host flushes once after power-up.
// R07: Cell-available bit 3 set while cells held.
// R08: Polling host waits for cell-available.
// R09: Interrupt per loaded cell when enabled.
// R10: Enable bit 5 gates extraction interrupt.
// R11: Loaded cell sets status bit 5, int low.
// R12: Word read as bytes, high byte first.
// R13: Filter counters saturate, clear on read.
// R14: After word fourteen, advance to next cell.
module rcx_device_end
  import rcx_pkg::*;
#(
  parameter int CELLS = 4
) (
  // Clock and reset
  input  wire logic      clk_sys_i,
  input  wire logic      reset_i,
  // Microprocessor link
  rcx_link_if.device     link,
  // Cells from the receive filter
  input  wire rcx_word_t in_word_i,
  input  wire logic      in_valid_i,
  input  wire logic      in_first_i,
  input  wire logic      in_copy_i,
  input  wire logic [3:0] filt_hit_i,
  // Status
  output logic           extract_cell_avail_o
);

  localparam int PW = $clog2(CELLS);
  localparam int IW = $clog2(CELLS * `RCX_WORDS_PER_CELL);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(CELLS - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  function automatic logic [IW-1:0] mem_idx(input logic [PW-1:0] p, input logic [3:0] w);
    return IW'(p * `RCX_WORDS_PER_CELL + w);
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  rcx_word_t                 mem [CELLS * `RCX_WORDS_PER_CELL];
  logic      [PW-1:0]        wr_ptr;
  logic      [PW-1:0]        rd_ptr;
  logic      [PW:0]          held;
  logic                      cap_act;
  logic      [3:0]           cap_word;
  logic      [3:0]           rd_word;
  logic                      flush_n;
  logic      [`RCX_INT_EN_W-1:0] int_en;
  logic      [`RCX_INT_EN_W-1:0] int_stat;
  rcx_word_t                 fcnt [`RCX_FILTERS];
  rcx_word_t                 fsnap [`RCX_FILTERS];

  logic                      full;
  logic                      cap_go;
  logic                      mem_we;
  logic      [3:0]           mem_wword;
  logic                      commit;
  logic                      overflow;
  logic                      word_rd;
  logic                      pop;
  logic      [1:0]           cnt_sel;
  logic                      cnt_acc;
  logic                      cnt_b3_rd;
  rcx_word_t                 cur_word;

  assign full      = (held == (PW + 1)'(CELLS));
  assign cap_go    = in_valid_i && in_first_i && in_copy_i && !full;
  assign overflow  = in_valid_i && in_first_i && in_copy_i && full;
  assign mem_we    = in_valid_i && (cap_go || (cap_act && !in_first_i));
  assign mem_wword = in_first_i ? 4'h0 : cap_word;
  assign commit    = mem_we && (mem_wword == `RCX_LAST_WORD) && flush_n;
  // The word pointer moves on the low byte, so the high byte must be read first.
  assign word_rd   = link.rd && (link.addr == `RCX_DATA_B0_ADDR) && (held != '0) && flush_n; // R12
  assign pop       = word_rd && (rd_word == `RCX_LAST_WORD); // R14
  assign cnt_acc   = ((link.addr & `RCX_CNT_ADDR_MASK) == `RCX_CNT_B3_ADDR);
  assign cnt_sel   = link.addr[5:4];
  assign cnt_b3_rd = link.rd && cnt_acc && (link.addr[1:0] == 2'b00);
  assign cur_word  = (held != '0) ? mem[mem_idx(rd_ptr, rd_word)] : '0;

  // ==========================================================================
  // Cell capture
  // ==========================================================================
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem[mem_idx(wr_ptr, mem_wword)] <= in_word_i; // R02 R03
    end
  end

  // A cell that starts before the previous one finished discards the fragment.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cap_act  <= 1'b0;
      cap_word <= 4'h0;
      wr_ptr   <= '0;
    end else if (!flush_n) begin
      cap_act  <= 1'b0;
      cap_word <= 4'h0;
      wr_ptr   <= '0; // R05
    end else if (in_valid_i) begin
      if (in_first_i) begin
        cap_act  <= cap_go;
        cap_word <= 4'h1;
      end else if (cap_act) begin
        cap_word <= cap_word + 4'h1;
        if (cap_word == `RCX_LAST_WORD) begin
          cap_act <= 1'b0;
          wr_ptr  <= next_ptr(wr_ptr); // R02
        end
      end
    end
  end

  // ==========================================================================
  // Cell read-out
  // ==========================================================================
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rd_ptr  <= '0;
      rd_word <= 4'h0;
      held    <= '0;
    end else if (!flush_n) begin
      rd_ptr  <= '0;
      rd_word <= 4'h0;
      held    <= '0; // R05
    end else begin
      if (word_rd) begin
        rd_word <= pop ? 4'h0 : rd_word + 4'h1; // R14
      end
      if (pop) begin
        rd_ptr <= next_ptr(rd_ptr); // R14
      end
      held <= (PW + 1)'(held + commit - pop); // R07
    end
  end

  assign extract_cell_avail_o = (held != '0); // R07

  // ==========================================================================
  // Control registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      flush_n <= 1'b1;
      int_en  <= `RCX_INT_EN_RESET;
    end else if (link.wr) begin
      if (link.addr == `RCX_MEMCTL_ADDR) begin
        flush_n <= link.wdata[`RCX_FLUSH_N_BIT]; // R05
      end
      if (link.addr == `RCX_INT_EN_ADDR) begin
        int_en <= link.wdata[`RCX_INT_EN_W-1:0]; // R10
      end
    end
  end

  // Sticky status, write one to clear; a new event in the clearing cycle wins.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      int_stat <= '0;
    end else begin
      for (int b = 0; b < `RCX_INT_EN_W; b++) begin
        if (link.wr && (link.addr == `RCX_INT_STAT_ADDR) && link.wdata[b]) begin
          int_stat[b] <= 1'b0;
        end
      end
      if (commit) begin
        int_stat[`RCX_EXTR_INT_BIT] <= 1'b1; // R09 R11
      end
      if (overflow) begin
        int_stat[`RCX_EXTR_OVF_BIT] <= 1'b1;
      end
    end
  end

  assign link.int_n = !(|(int_stat & int_en)); // R10 R11

  // ==========================================================================
  // Filtered-cell counters
  // ==========================================================================
  // Reading the top byte snapshots and clears the counter; the lower bytes
  // come from the snapshot so the four reads form one coherent value.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int f = 0; f < `RCX_FILTERS; f++) begin
        fcnt[f]  <= '0;
        fsnap[f] <= '0;
      end
    end else begin
      for (int f = 0; f < `RCX_FILTERS; f++) begin
        if (cnt_b3_rd && (cnt_sel == 2'(f))) begin
          fsnap[f] <= fcnt[f]; // R01
          fcnt[f]  <= {31'h0, filt_hit_i[f]}; // R13
        end else if (filt_hit_i[f] && (fcnt[f] != 32'hffffffff)) begin
          fcnt[f] <= fcnt[f] + 32'h1; // R13
        end
      end
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe
  // ==========================================================================
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      link.rdata <= 8'h00;
    end else if (link.rd) begin
      if (cnt_acc) begin
        unique case (link.addr[1:0])
          2'b00:   link.rdata <= fcnt[cnt_sel][31:24]; // R01
          2'b01:   link.rdata <= fsnap[cnt_sel][23:16];
          2'b10:   link.rdata <= fsnap[cnt_sel][15:8];
          2'b11:   link.rdata <= fsnap[cnt_sel][7:0];
        endcase
      end else begin
        case (link.addr)
          `RCX_MEMCTL_ADDR:   link.rdata <= {3'h0, flush_n, (held != '0), 3'h0}; // R07
          `RCX_INT_EN_ADDR:   link.rdata <= {2'h0, int_en};
          `RCX_INT_STAT_ADDR: link.rdata <= {2'h0, int_stat};
          `RCX_DATA_B3_ADDR:  link.rdata <= cur_word[31:24]; // R12
          12'h715:            link.rdata <= cur_word[23:16];
          12'h716:            link.rdata <= cur_word[15:8];
          `RCX_DATA_B0_ADDR:  link.rdata <= cur_word[7:0];
          default:            link.rdata <= 8'h00;
        endcase
      end
    end else begin
      link.rdata <= 8'h00;
    end
  end

endmodule

// ---- verilog/rcx_host_end.sv ----
`timescale 1ns/1ps
`include "rcx_defs.svh"

module rcx_host_end
  import rcx_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  // Microprocessor link
  rcx_link_if.host        link,
  // Command port
  input  wire logic [5:0] cmd_addr_i,
  input  wire rcx_word_t  cmd_wdata_i,
  input  wire logic       cmd_wr_i,
  input  wire logic       cmd_rd_i,
  output rcx_word_t       cmd_rdata_o,
  output logic            irq_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  rcx_host_state_t state;
  logic      [1:0] bsel;
  logic      [3:0] word;
  logic      [1:0] filt;
  rcx_word_t       acc;
  rcx_word_t       count;
  rcx_word_t       cellw [`RCX_WORDS_PER_CELL];
  logic      [1:0] irq_stat;
  logic      [1:0] irq_mask;
  logic            ev_cell;
  logic            ev_cnt;
  logic            busy;
  logic            cmd_wr;
  rcx_addr_t       wr_addr;
  rcx_byte_t       wr_data;

  assign busy    = (state != RCX_ST_IDLE);
  assign cmd_wr  = cmd_wr_i && (cmd_addr_i == `RCX_H_CMD_ADDR) && !busy;
  assign ev_cell = (state == RCX_ST_DATA_CAP) && (bsel == 2'h3) && (word == `RCX_LAST_WORD);
  assign ev_cnt  = (state == RCX_ST_CNT_CAP) && (bsel == 2'h3);

  // ==========================================================================
  // Link drive, decoded from the registered state
  // ==========================================================================
  always_comb begin
    link.wr    = (state == RCX_ST_FLUSH_LO) || (state == RCX_ST_FLUSH_HI); // R05
    link.rd    = (state == RCX_ST_POLL_RD) || (state == RCX_ST_DATA_RD) || (state == RCX_ST_CNT_RD);
    // The second write state carries any single register write, flush release included.
    link.wdata = (state == RCX_ST_FLUSH_HI) ? wr_data : `RCX_MEMCTL_FLUSH;
    link.addr  = (state == RCX_ST_FLUSH_HI) ? wr_addr : `RCX_MEMCTL_ADDR; // R10
    if (state == RCX_ST_DATA_RD) begin
      link.addr = `RCX_DATA_B3_ADDR + {10'h0, bsel}; // R12
    end else if (state == RCX_ST_CNT_RD) begin
      link.addr = `RCX_CNT_B3_ADDR + {6'h0, filt, 2'h0, bsel}; // R01
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Reset starts with a flush so stale buffer contents never reach software.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= RCX_ST_FLUSH_LO; // R06
      bsel  <= 2'h0;
      word  <= 4'h0;
      filt  <= 2'h0;
      acc   <= '0;
      wr_addr <= `RCX_MEMCTL_ADDR;
      wr_data <= `RCX_MEMCTL_RUN;
    end else begin
      unique case (state)
        RCX_ST_FLUSH_LO: state <= RCX_ST_FLUSH_HI; // R05
        RCX_ST_FLUSH_HI: state <= RCX_ST_IDLE;
        RCX_ST_IDLE: begin
          bsel <= 2'h0;
          word <= 4'h0;
          if (cmd_wr) begin
            filt <= cmd_wdata_i[5:4];
            if (cmd_wdata_i[`RCX_H_CMD_FLUSH]) begin
              wr_addr <= `RCX_MEMCTL_ADDR;
              wr_data <= `RCX_MEMCTL_RUN;
              state   <= RCX_ST_FLUSH_LO;
            end else if (cmd_wdata_i[`RCX_H_CMD_CELL]) begin
              state <= RCX_ST_POLL_RD;
            end else if (cmd_wdata_i[`RCX_H_CMD_COUNT]) begin
              state <= RCX_ST_CNT_RD;
            end else if (cmd_wdata_i[`RCX_H_CMD_REG]) begin
              // Device register write: offset in bits 27:16, data in bits 15:8.
              wr_addr <= cmd_wdata_i[27:16]; // R10
              wr_data <= cmd_wdata_i[15:8];
              state   <= RCX_ST_FLUSH_HI;
            end
          end
        end
        RCX_ST_POLL_RD:  state <= RCX_ST_POLL_CHK;
        RCX_ST_POLL_CHK: state <= link.rdata[`RCX_CLAV_BIT] ? RCX_ST_DATA_RD : RCX_ST_POLL_RD; // R08
        RCX_ST_DATA_RD:  state <= RCX_ST_DATA_CAP;
        RCX_ST_DATA_CAP: begin
          acc  <= {acc[23:0], link.rdata}; // R12
          bsel <= bsel + 2'h1;
          if (bsel == 2'h3) begin
            word  <= word + 4'h1;
            state <= (word == `RCX_LAST_WORD) ? RCX_ST_IDLE : RCX_ST_DATA_RD; // R04
          end else begin
            state <= RCX_ST_DATA_RD;
          end
        end
        RCX_ST_CNT_RD:   state <= RCX_ST_CNT_CAP;
        RCX_ST_CNT_CAP: begin
          acc   <= {acc[23:0], link.rdata}; // R01
          bsel  <= bsel + 2'h1;
          state <= (bsel == 2'h3) ? RCX_ST_IDLE : RCX_ST_CNT_RD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if ((state == RCX_ST_DATA_CAP) && (bsel == 2'h3)) begin
      cellw[word] <= {acc[23:0], link.rdata}; // R03
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      count <= '0;
    end else if (ev_cnt) begin
      count <= {acc[23:0], link.rdata};
    end
  end

  // ==========================================================================
  // Events and command port registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      if (cmd_wr_i && (cmd_addr_i == `RCX_H_IRQ_STAT_ADDR)) begin
        irq_stat <= irq_stat & ~cmd_wdata_i[1:0];
      end
      if (cmd_wr_i && (cmd_addr_i == `RCX_H_IRQ_MASK_ADDR)) begin
        irq_mask <= cmd_wdata_i[1:0];
      end
      if (ev_cell) begin
        irq_stat[`RCX_H_EV_CELL] <= 1'b1;
      end
      if (ev_cnt) begin
        irq_stat[`RCX_H_EV_COUNT] <= 1'b1;
      end
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_rdata_o <= '0;
    end else if (cmd_rd_i) begin
      if (cmd_addr_i >= `RCX_H_CELL_BASE && cmd_addr_i < `RCX_H_CELL_BASE + 6'(`RCX_WORDS_PER_CELL)) begin
        cmd_rdata_o <= cellw[4'(cmd_addr_i - `RCX_H_CELL_BASE)];
      end else begin
        case (cmd_addr_i)
          `RCX_H_CMD_ADDR:      cmd_rdata_o <= {30'h0, !link.int_n, busy};
          `RCX_H_IRQ_STAT_ADDR: cmd_rdata_o <= {30'h0, irq_stat};
          `RCX_H_IRQ_MASK_ADDR: cmd_rdata_o <= {30'h0, irq_mask};
          `RCX_H_COUNT_ADDR:    cmd_rdata_o <= count;
          default:              cmd_rdata_o <= '0;
        endcase
      end
    end else begin
      cmd_rdata_o <= '0;
    end
  end

endmodule

// ---- verification/rcx_link_sva.sv ----
`timescale 1ns/1ps
`include "rcx_defs.svh"

module rcx_link_sva
  import rcx_pkg::*;
(
  // Clock and reset
  input wire logic      clk_sys_i,
  input wire logic      reset_i,
  // Link signals
  input wire rcx_addr_t addr,
  input wire rcx_byte_t wdata,
  input wire logic      wr,
  input wire logic      rd,
  input wire rcx_byte_t rdata,
  input wire logic      int_n
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic [3:0] words;
  logic [5:0] en_q;
  logic       rdata_b3;

  assign rdata_b3 = rdata[3];

  // Words read since the last poll; a poll always starts a fresh cell.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      words <= 4'h0;
    end else if (rd && addr == `RCX_MEMCTL_ADDR) begin
      words <= 4'h0;
    end else if (rd && addr == `RCX_DATA_B0_ADDR) begin
      words <= words + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      en_q <= 6'h00;
    end else if (wr && addr == `RCX_INT_EN_ADDR) begin
      en_q <= wdata[5:0];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_strobe_excl; !(rd && wr); endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
  property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer");
  property p_flush_pair; !reset_i && wr && addr == `RCX_MEMCTL_ADDR && wdata == 8'h00 |=> wr && addr == `RCX_MEMCTL_ADDR && wdata == 8'h10; endproperty
  a_flush_pair: assert property (p_flush_pair) else $error("flush low not followed by flush high");
  property p_ctrl_fmt; rd && addr == `RCX_MEMCTL_ADDR |=> rdata[7:4] == 4'h1 && rdata[2:0] == 3'b000; endproperty
  a_ctrl_fmt: assert property (p_ctrl_fmt) else $error("control register read has wrong fixed bits");
  property p_int_gate; en_q[5] == 1'b0 && en_q[3] == 1'b0 |-> int_n; endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt low while disabled");
  property p_cnt_order; rd && (addr & 12'hfcc) == 12'h74c && addr[1:0] != 2'b00 |-> $past(rd, 2) && $past(addr, 2) == addr - 12'h001; endproperty
  a_cnt_order: assert property (p_cnt_order) else $error("counter bytes out of order");
  property p_data_order; rd && addr inside {12'h715, 12'h716, 12'h717} |-> $past(rd, 2) && $past(addr, 2) == addr - 12'h001; endproperty
  a_data_order: assert property (p_data_order) else $error("cell bytes out of order");
  property p_data_start; rd && addr == `RCX_DATA_B3_ADDR |-> $past(rd, 2) && ($past(addr, 2) == 12'h717 || ($past(addr, 2) == 12'h713 && $past(rdata_b3))); endproperty
  a_data_start: assert property (p_data_start) else $error("cell read started without cell available");
  property p_word_count; rd && addr == `RCX_MEMCTL_ADDR |-> words == 4'h0 || words == 4'he; endproperty
  a_word_count: assert property (p_word_count) else $error("cell not read as fourteen words");
  property p_cell_done; rd && addr == `RCX_DATA_B3_ADDR && words == 4'h0 |-> ##[1:120] (rd && addr == `RCX_DATA_B0_ADDR && words == 4'hd); endproperty
  a_cell_done: assert property (p_cell_done) else $error("cell read not completed in time");
endmodule

// ---- verification/rx_cell_extraction_buffer_tb.sv ----
`timescale 1ns/1ps
`include "rcx_defs.svh"

module rx_cell_extraction_buffer_tb
  import rcx_pkg::*;
;
  logic       clk_sys_i;
  logic       reset_i;
  rcx_word_t  in_word;
  logic       in_valid;
  logic       in_first;
  logic       in_copy;
  logic [3:0] filt_hit;
  logic       avail;
  logic [5:0] cmd_addr;
  rcx_word_t  cmd_wdata;
  logic       cmd_wr;
  logic       cmd_rd;
  rcx_word_t  cmd_rdata;
  logic       irq;
  int         failures;
  int         samples_checked;
  rcx_word_t  v;

  rcx_link_if u_rcx_link_if ();

  rcx_device_end #(.CELLS(4)) u_rcx_device_end (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_rcx_link_if),
    .in_word_i(in_word), .in_valid_i(in_valid), .in_first_i(in_first), .in_copy_i(in_copy),
    .filt_hit_i(filt_hit), .extract_cell_avail_o(avail));

  rcx_host_end u_rcx_host_end (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(u_rcx_link_if),
    .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd),
    .cmd_rdata_o(cmd_rdata), .irq_o(irq));

  rcx_link_sva u_rcx_link_sva (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr(u_rcx_link_if.addr),
    .wdata(u_rcx_link_if.wdata), .wr(u_rcx_link_if.wr), .rd(u_rcx_link_if.rd),
    .rdata(u_rcx_link_if.rdata), .int_n(u_rcx_link_if.int_n));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  always #2.5 clk_sys_i = ~clk_sys_i;

  task automatic check(input rcx_word_t got, input rcx_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmd_write(input logic [5:0] a, input rcx_word_t d);
    @(posedge clk_sys_i);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    @(posedge clk_sys_i);
    cmd_wr <= 1'b0;
    #1;
  endtask

  task automatic cmd_read(input logic [5:0] a, output rcx_word_t d);
    @(posedge clk_sys_i);
    cmd_addr <= a;
    cmd_rd   <= 1'b1;
    @(posedge clk_sys_i);
    cmd_rd <= 1'b0;
    #1;
    d = cmd_rdata;
  endtask

  // Bounded so that a stuck busy flag ends up as a mismatch, not a hang.
  task automatic wait_idle();
    rcx_word_t s;
    int k;
    s = 32'h1;
    k = 0;
    while (s[0] !== 1'b0 && k < 600) begin
      cmd_read(6'h00, s);
      k++;
    end
    if (k >= 600) begin
      failures++;
      $display("[ERR] t=%0t busy never cleared", $time);
    end
  endtask

  task automatic send_cell(input logic [23:0] base, input logic copy, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      in_word  <= {base, 8'(i)};
      in_valid <= 1'b1;
      in_first <= (i == 0);
      in_copy  <= copy && (i == 0);
    end
    @(posedge clk_sys_i);
    in_valid <= 1'b0;
    in_first <= 1'b0;
    in_copy  <= 1'b0;
    #1;
  endtask

  task automatic get_cell(input logic [23:0] base);
    rcx_word_t w;
    wait_idle();
    for (int i = 0; i < 14; i++) begin
      cmd_read(6'(16 + i), w);
      check(w, {base, 8'(i)});
    end
  endtask

  task automatic read_cell(input logic [23:0] base);
    cmd_write(6'h00, 32'h2);
    get_cell(base);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk_sys_i = 1'b0;
    reset_i = 1'b1;
    {in_word, in_valid, in_first, in_copy, filt_hit} = '0;
    {cmd_addr, cmd_wdata, cmd_wr, cmd_rd} = '0;
    failures = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    check(32'(avail), 32'h0);
    cmd_write(6'h02, 32'h0);
    // Empty buffer: the host must keep polling until a cell shows up.
    cmd_write(6'h00, 32'h2);
    repeat (60) @(posedge clk_sys_i);
    cmd_read(6'h00, v);
    check(v & 32'h3, 32'h1);
    send_cell(24'ha1b2c3, 1'b1, 14);
    get_cell(24'ha1b2c3);
    check(32'(avail), 32'h0);
    cmd_read(6'h01, v);
    check(v & 32'h3, 32'h1);
    check(32'(irq), 32'h0);
    cmd_write(6'h02, 32'h1);
    check(32'(irq), 32'h1);
    cmd_write(6'h01, 32'h1);
    check(32'(irq), 32'h0);
    // Stored copy, ignored non-copy, aborted partial, then a full copy.
    send_cell(24'h111111, 1'b1, 14);
    send_cell(24'h222222, 1'b0, 14);
    send_cell(24'h333333, 1'b1, 5);
    send_cell(24'h444444, 1'b1, 14);
    check(32'(avail), 32'h1);
    read_cell(24'h111111);
    check(32'(avail), 32'h1);
    read_cell(24'h444444);
    check(32'(avail), 32'h0);
    // Flush empties the buffer, which works again afterwards.
    send_cell(24'h555555, 1'b1, 14);
    check(32'(avail), 32'h1);
    cmd_write(6'h00, 32'h1);
    wait_idle();
    check(32'(avail), 32'h0);
    send_cell(24'h666666, 1'b1, 14);
    read_cell(24'h666666);
    // Interrupt path: clear stale status, enable, then one new cell raises it.
    cmd_write(6'h00, 32'h070b2808);
    wait_idle();
    cmd_write(6'h00, 32'h070f2008);
    wait_idle();
    cmd_read(6'h00, v);
    check(v & 32'h3, 32'h0);
    send_cell(24'h777777, 1'b1, 14);
    cmd_read(6'h00, v);
    check(v & 32'h3, 32'h2);
    read_cell(24'h777777);
    cmd_write(6'h00, 32'h070b2008);
    wait_idle();
    cmd_read(6'h00, v);
    check(v & 32'h3, 32'h0);
    // Counters: each filter counts its own hits and clears on read.
    for (int f = 0; f < 4; f++) begin
      repeat (f + 1) begin
        @(posedge clk_sys_i);
        filt_hit <= 4'(1 << f);
        @(posedge clk_sys_i);
        filt_hit <= 4'h0;
      end
      for (int r = 0; r < 2; r++) begin
        cmd_write(6'h00, 32'(4 + 16 * f));
        wait_idle();
        cmd_read(6'h03, v);
        check(v, (r == 0) ? 32'(f + 1) : 32'h0);
      end
    end
    cmd_read(6'h01, v);
    check(v & 32'h2, 32'h2);
    cmd_write(6'h01, 32'h3);
    cmd_read(6'h01, v);
    check(v & 32'h3, 32'h0);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    $display("[ERR] t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
